// *** rtl/adccc_pkg.sv ***
/*
 * Package for the converter control block: register offset, field positions,
 * start-source codes, reset value and conversion timing.
 * Assumes a single 25 MHz system clock shared by all users.
 */
package adccc_pkg;

    // Register placement in the special-function space
    localparam logic [7:0] CTRL_ADDR       = 8'hE8;
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // Field positions
    localparam int         ENABLE_BIT      = 7;
    localparam int         TRACK_BIT       = 6;
    localparam int         DONE_BIT        = 5;
    localparam int         BUSY_BIT        = 4;
    localparam int         SRC_HI          = 3;
    localparam int         SRC_LO          = 2;

    // Start-source codes
    typedef enum logic [1:0] {
        ADCCC_SRC_WRITE = 2'b00,
        ADCCC_SRC_TIMER = 2'b01,
        ADCCC_SRC_PIN   = 2'b10,
        ADCCC_SRC_SPARE = 2'b11
    } adccc_src_t;

    // Conversion length in system clocks (plain default)
    localparam int         CONV_CYCLES     = 16;

endpackage : adccc_pkg

// *** rtl/adccc_ctrl.sv ***
/*
 * Converter control and status register with start-source selection,
 * busy tracking and a sticky conversion-complete flag.
 * Assumes a byte-wide register port from the core, a timer overflow pulse on
 * the same clock, and an asynchronous external start pin.
 * The analog core, calibration and result data are outside this block.
 */
//
// Contract
// R1 - Enable low holds converter off, no conversions
// R2 - Enable high lets converter accept starts
// R3 - Track mode 0: track unless converting
// R4 - Track mode 1: tracking set by start source
// R5 - Done flag shows a finished conversion
// R6 - Done flag set on busy falling edge
// R7 - Only software clears done flag
// R8 - Busy reads 1 while converting
// R9 - Busy write 1 starts only with code 00
// R10 - Source field bits 3-2; 00 is write
// R11 - Code 01 starts on timer overflow
// R12 - Code 10 starts on pin rising edge
// R13 - Code 11 and tracking are parameters
`timescale 1ns/1ps

module adccc_ctrl
    import adccc_pkg::*;
#(
    parameter int         CONV_LEN    = CONV_CYCLES,
    parameter logic       SPARE_START = 1'b0,
    parameter logic [3:0] TRACK_MAP   = 4'h0
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       timer3_overflow,
    input  wire logic       external_start_pin,
    output logic            converter_powered,
    output logic            converter_tracking,
    output logic            convert_strobe
);

    // Counter wide enough to hold CONV_LEN - 1
    localparam int CW = $clog2(CONV_LEN + 1);

    // Sequencer states; busy is simply the CONV state
    typedef enum logic [0:0] {
        ADCCC_IDLE = 1'b0,
        ADCCC_CONV = 1'b1
    } adccc_state_t;

    // Software fields and sequencer state
    logic         converter_enable_reg;
    logic         track_mode_select_reg;
    logic         conversion_done_flag_reg;
    logic [1:0]   start_source_select_reg;
    adccc_state_t state_reg;
    logic [CW-1:0] count_reg;
    logic [2:0]   pin_sync_reg;
    logic         pin_level_reg;
    logic         busy_prev_reg;

    // Decode nets
    logic         ctrl_wr;
    logic         pin_rise;
    logic         spare_trig;
    logic         start_req;
    logic         conversion_busy;
    logic         busy_fall;

    // Full address decode; other offsets are left alone
    assign ctrl_wr         = reg_wr && (reg_addr == CTRL_ADDR);
    assign conversion_busy = (state_reg == ADCCC_CONV); // [R8]

    // Pin: three stages, change accepted once the last two agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_start_pin};
            // Level follows only when the last two stages agree
            if (pin_sync_reg[2] == pin_sync_reg[1])
            begin
                pin_level_reg <= pin_sync_reg[2];
            end
        end
    end

    // Rise only on an agreed change, so a one-clock glitch never starts
    assign pin_rise   = (pin_sync_reg[2] == pin_sync_reg[1]) &&
                        pin_sync_reg[2] && !pin_level_reg;
    // Code 11 stays inert by default until its meaning is settled
    assign spare_trig = SPARE_START && ctrl_wr && reg_wdata[BUSY_BIT]; // [R13]

    // Start decode per source; busy write 0 never starts anything
    always_comb
    begin
        case (adccc_src_t'(start_source_select_reg))
            ADCCC_SRC_WRITE: start_req = ctrl_wr && reg_wdata[BUSY_BIT]; // [R9] [R10]
            ADCCC_SRC_TIMER: start_req = timer3_overflow;  // [R11]
            ADCCC_SRC_PIN:   start_req = pin_rise;         // [R12]
            ADCCC_SRC_SPARE: start_req = spare_trig;       // [R13]
            default:         start_req = 1'b0;
        endcase
    end

    // Control fields written by software
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            converter_enable_reg    <= CTRL_RESET[ENABLE_BIT];
            track_mode_select_reg   <= CTRL_RESET[TRACK_BIT];
            start_source_select_reg <= CTRL_RESET[SRC_HI:SRC_LO];
        end
        else if (ctrl_wr)
        begin
            converter_enable_reg    <= reg_wdata[ENABLE_BIT];
            track_mode_select_reg   <= reg_wdata[TRACK_BIT];
            start_source_select_reg <= reg_wdata[SRC_HI:SRC_LO];
        end
    end

    // Conversion sequencer; disabling aborts a running conversion
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ADCCC_IDLE;
            count_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ADCCC_IDLE:
                begin
                    // Starts while disabled or busy are dropped, not queued
                    if (converter_enable_reg && start_req) // [R1] [R2]
                    begin
                        state_reg <= ADCCC_CONV;
                        count_reg <= CW'(CONV_LEN - 1);
                    end
                end
                ADCCC_CONV:
                begin
                    if (!converter_enable_reg) // [R1]
                    begin
                        state_reg <= ADCCC_IDLE;
                    end
                    else if (count_reg == '0)
                    begin
                        state_reg <= ADCCC_IDLE;
                    end
                    else
                    begin
                        count_reg <= count_reg - 1'b1;
                    end
                end
                default: state_reg <= ADCCC_IDLE;
            endcase
        end
    end

    // Previous busy, for the falling-edge detector of the done flag
    // Reset matches idle, so no false fall follows reset
    always_ff @(posedge clk)
    begin
        if (rst)
            busy_prev_reg <= 1'b0;
        else
            busy_prev_reg <= conversion_busy;
    end

    // An abort on disable is a fall too, so done still sets
    assign busy_fall = busy_prev_reg && !conversion_busy;

    // Sticky done flag: a set in the same cycle as a clear wins
    // Writing 1 to the done bit keeps it; only hardware sets it
    always_ff @(posedge clk)
    begin
        if (rst)
            conversion_done_flag_reg <= CTRL_RESET[DONE_BIT];
        else if (busy_fall)
            conversion_done_flag_reg <= 1'b1; // [R5] [R6]
        else if (ctrl_wr && !reg_wdata[DONE_BIT])
            conversion_done_flag_reg <= 1'b0; // [R7]
    end

    // Registered outputs
    // Read data lags the fields by one clock; reads have no side effects
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reg_rdata          <= CTRL_RESET;
            converter_powered  <= 1'b0;
            converter_tracking <= 1'b0;
            convert_strobe     <= 1'b0;
        end
        else
        begin
            reg_rdata <= {converter_enable_reg, track_mode_select_reg,
                          conversion_done_flag_reg, conversion_busy,
                          start_source_select_reg, 2'b00};
            converter_powered <= converter_enable_reg; // [R1] [R2]
            // Tracking pauses for the whole conversion
            if (!track_mode_select_reg)
                converter_tracking <= converter_enable_reg && !conversion_busy; // [R3]
            else
                converter_tracking <= converter_enable_reg && !conversion_busy &&
                                      TRACK_MAP[start_source_select_reg]; // [R4] [R13]
            // One-clock pulse for each accepted start
            convert_strobe <= converter_enable_reg && start_req &&
                              (state_reg == ADCCC_IDLE);
        end
    end

endmodule : adccc_ctrl

// *** sim/adccc_chk.sv ***
/* Port checker for adccc_ctrl.
   Assumes CONV_LEN of 4 and one start source active at a time. */
`timescale 1ns/1ps
module adccc_chk
    import adccc_pkg::*;
#(parameter int CONV_LEN = 4)
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer3_overflow,
    input wire logic       external_start_pin,
    input wire logic       converter_powered,
    input wire logic       converter_tracking,
    input wire logic       convert_strobe
);
    logic wr_e8;
    logic clr_w;
    // Write decode; a clear reaches rdata two edges later
    assign wr_e8 = reg_wr && reg_addr == CTRL_ADDR;
    assign clr_w = wr_e8 && !reg_wdata[5];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Enabled and idle, no write just before
    sequence idle_s;
        converter_powered && !reg_rdata[4] && !convert_strobe && !$past(reg_wr);
    endsequence
    chk_off_no_start: assert property (
        !converter_powered && !$past(converter_powered) |-> !convert_strobe)
        else $error("start while disabled");
    chk_write_start: assert property (
        idle_s ##0 (wr_e8 && reg_wdata[7] && reg_wdata[4] && reg_wdata[3:2] == 2'h0
        && reg_rdata[3:2] == 2'h0) |=> convert_strobe)
        else $error("busy write did not start");
    chk_busy_refused: assert property (
        wr_e8 && reg_wdata[4] && reg_wdata[3:2] != 2'h0 && reg_rdata[3:2] != 2'h0
        && !$past(reg_wr) && !timer3_overflow |=> !convert_strobe) else $error("bad start");
    // Start with the converter left on for the whole conversion
    sequence run_s;
        convert_strobe ##1 converter_powered [*4];
    endsequence
    chk_busy_span: assert property (
        run_s |-> ($past(reg_rdata[4], 3) && $past(reg_rdata[4], 2) && $past(reg_rdata[4])
        && reg_rdata[4]) ##1 !reg_rdata[4]) else $error("busy length");
    chk_off_stops: assert property (
        !converter_powered |=> !reg_rdata[4]) else $error("busy while disabled");
    chk_done_sets: assert property (
        $fell(reg_rdata[4]) |-> ##[0:1] reg_rdata[5]) else $error("done not set");
    chk_done_sticky: assert property (
        $fell(reg_rdata[5]) |-> $past(clr_w, 2)) else $error("done lost");
    chk_timer_start: assert property (
        idle_s ##0 (timer3_overflow && reg_rdata[3:2] == 2'h1) |=> convert_strobe)
        else $error("timer start missed");
    chk_pin_start: assert property (
        idle_s ##0 ($rose(external_start_pin) && reg_rdata[3:2] == 2'h2)
        |-> ##[2:6] convert_strobe) else $error("pin start missed");
endmodule : adccc_chk
bind adccc_ctrl adccc_chk #(.CONV_LEN(CONV_LEN)) u_chk (
    .clk                (clk),
    .rst                (rst),
    .reg_addr           (reg_addr),
    .reg_wr             (reg_wr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .timer3_overflow    (timer3_overflow),
    .external_start_pin (external_start_pin),
    .converter_powered  (converter_powered),
    .converter_tracking (converter_tracking),
    .convert_strobe     (convert_strobe)
);

// *** sim/tb_top.sv ***
/* Bench for adccc_ctrl: register writes, timer and pin starts.
   Assumes adccc_chk is bound in from its own file. */
`timescale 1ns/1ps
module tb_top;
    import adccc_pkg::*;
    logic       clk, rst, reg_wr, timer3_overflow, external_start_pin;
    logic       converter_powered, converter_tracking, convert_strobe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    int         error_cnt, total_checks, stb_cnt;
    adccc_ctrl #(
        .CONV_LEN  (4),
        .TRACK_MAP (4'h2)
    ) dut (
        .clk                (clk),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wr             (reg_wr),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .timer3_overflow    (timer3_overflow),
        .external_start_pin (external_start_pin),
        .converter_powered  (converter_powered),
        .converter_tracking (converter_tracking),
        .convert_strobe     (convert_strobe)
    );
    // 25 MHz clock
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // Start pulses seen
    always @(negedge clk) if (convert_strobe === 1'b1) stb_cnt++;
    task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // One-cycle write, driven off the sampling edge
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Sequence of register and start-source tests
    initial
    begin
        {rst, reg_wr, timer3_overflow, external_start_pin, reg_addr, reg_wdata} = 20'h80000;
        idle(12);
        rst = 1'b0;
        idle(2);
        chk("reset", reg_rdata, 8'h00);
        wr(CTRL_ADDR, 8'h10);
        idle(8);
        chk("off", {converter_powered, 3'h0, stb_cnt[3:0]}, 8'h00);
        wr(CTRL_ADDR, 8'h80);
        idle(3);
        chk("on", {6'h00, converter_powered, converter_tracking}, 8'h03);
        wr(8'h55, 8'h90);
        idle(8);
        chk("other", reg_rdata, 8'h80);
        wr(CTRL_ADDR, 8'h90);
        idle(2);
        chk("busy", {reg_rdata[7:1], converter_tracking}, 8'h90);
        idle(8);
        chk("done", reg_rdata, 8'hA0);
        wr(CTRL_ADDR, 8'hA0);
        idle(2);
        chk("keep", reg_rdata, 8'hA0);
        wr(CTRL_ADDR, 8'h84);
        wr(CTRL_ADDR, 8'h94);
        idle(8);
        chk("refuse", {reg_rdata[7:4], stb_cnt[3:0]}, 8'h81);
        timer3_overflow = 1'b1;
        idle(1);
        timer3_overflow = 1'b0;
        idle(10);
        chk("timer", {reg_rdata[7:4], stb_cnt[3:0]}, 8'hA2);
        wr(CTRL_ADDR, 8'h88);
        idle(2);
        external_start_pin = 1'b1;
        idle(14);
        chk("pin", {reg_rdata[7:4], stb_cnt[3:0]}, 8'hA3);
        wr(CTRL_ADDR, 8'h9C);
        idle(8);
        chk("spare", {reg_rdata[7:4], stb_cnt[3:0]}, 8'h83);
        wr(CTRL_ADDR, 8'h80);
        wr(CTRL_ADDR, 8'h90);
        wr(CTRL_ADDR, 8'h00);
        idle(2);
        chk("abort", {reg_rdata[7:4], stb_cnt[3:0]}, 8'h04);
        idle(2);
        chk("abort done", reg_rdata, 8'h20);
        wr(CTRL_ADDR, 8'hC4);
        idle(2);
        chk("track map 1", {7'h00, converter_tracking}, 8'h01);
        wr(CTRL_ADDR, 8'hC0);
        idle(2);
        chk("track map 0", {7'h00, converter_tracking}, 8'h00);
        summarize();
    end
    // Tests need about 125 cycles
    initial
    begin
        #40000;
        error_cnt++;
        summarize();
    end
endmodule : tb_top
